// file: tw_master.sv
`timescale 1ns/1ps
`include "tw_cfg.svh"
// Notes on behaviour
// - Receive: ack pulse if enabled, then event and byte-done flags, irq if enabled
// - After received byte SCL held low until status read then data read
// - Transmit: SCL held low until status read then data write, then shift
// - Transmit: after slave ack, event and byte-done flags set unless stop requested, irq if enabled
// - Missing ack sets event and nack flags, SCL released; resume by start/stop
// - Nack after address cleared by status read alone, with the event flag
// - Enable low holds control and status reset and releases bus pins
// - First enabling write sets only the enable; pins then belong to block
// - Start request makes start or repeated start; cleared when sent or disabled
// - Ack enable returns ack after received bytes; cleared on disable
// - Stop request in master mode stops after byte or start; then cleared
// - Irq enable gates event interrupts; cleared on disable
// - Event flag set on byte-done, start, nack, address sent
// - Direction flag reads 1 for transmitted byte; clears with byte-done
// - Transmit byte-done after ack clock, after address only past that event
// - Receive byte-done after ack pulse; SCL low while byte-done set
// - Master flag set by start write, cleared after stop or disable
// - Start-sent flag cleared by status read then address write
// - Speed select chooses fast or standard; unchanged by disable
// - SCL period 3*(D+3) fast or 2*(D+3)+1 standard, D at least 3
// - Data write in transmit launches that byte on the bus
module tw_master
    import tw_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic pins_owned,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    tw_state_t s;
    tw_state_t n;
    logic cr_wr;
    logic dr_wr;
    logic dr_rd;
    logic sr_rd;
    logic is_tx;
    logic drive;
    logic lo_done;
    logic hi_done;
    logic [7:0] base;
    logic [7:0] len_lo;
    logic [7:0] len_hi;
    logic [7:0] cr_val;
    logic [7:0] sr_val;
    logic [7:0] ccr_val;

    // Address match of one register
    function automatic logic is_reg(input logic [7:0] a,
                                    input logic [7:0] o);
        return a == o;
    endfunction

    // Enter a sequencer state; event flags of the old step drop
    function automatic tw_state_t go_to(input tw_state_t x,
                                        input tw_st_t st,
                                        input logic [1:0] ph,
                                        input logic gs);
        tw_state_t y;
        y = x;
        y.st = st;
        y.phase = ph;
        y.cnt = '0;
        y.bitn = '0;
        y.gstop = gs;
        y.event_flag = 1'b0;
        y.byte_done = 1'b0;
        y.tx_direction = 1'b0;
        y.sb = 1'b0;
        y.af = 1'b0;
        y.sr_seen = 1'b0;
        return y;
    endfunction

    // Register strobes
    assign cr_wr = reg_wr && is_reg(reg_addr, `TW_CR_OFF);
    assign dr_wr = reg_wr && is_reg(reg_addr, `TW_DR_OFF);
    assign dr_rd = reg_rd && is_reg(reg_addr, `TW_DR_OFF);
    assign sr_rd = reg_rd && is_reg(reg_addr, `TW_SR_OFF);

    // Bit phase lengths from the divider
    assign base = ((s.div < `TW_DIV_MIN) ? {2'b00, `TW_DIV_MIN}
                  : {2'b00, s.div}) + `TW_DIV_ADD;
    assign len_hi = base;
    assign len_lo = s.speed ? {base[6:0], 1'b0}
                  : base + `TW_FM_EXTRA;
    // High phase gains one cycle while SCL rises, so low gives one back
    assign lo_done = s.cnt >= len_lo - `TW_LO_TRIM;
    assign hi_done = s.cnt >= len_hi - `TW_FM_EXTRA;

    // Address and data bytes we send, versus data we receive
    assign is_tx = s.addr_ph || !s.rx_mode;
    assign drive = (s.bitn == `TW_LAST_BIT) ? (!is_tx && s.ack)
                 : (is_tx && !s.shreg[7]);

    // Readable register images
    always_comb begin
        cr_val = `TW_ZERO_BYTE;
        cr_val[`TW_CR_PE] = s.pe;
        cr_val[`TW_CR_START] = s.start;
        cr_val[`TW_CR_ACK] = s.ack;
        cr_val[`TW_CR_STOP] = s.stop;
        cr_val[`TW_CR_ITE] = s.irq_enable;
        sr_val = `TW_ZERO_BYTE;
        sr_val[`TW_SR_EVF] = s.event_flag;
        sr_val[`TW_SR_AF] = s.af;
        sr_val[`TW_SR_TRA] = s.tx_direction;
        sr_val[`TW_SR_BTF] = s.byte_done;
        sr_val[`TW_SR_MST] = s.mst;
        sr_val[`TW_SR_SB] = s.sb;
        ccr_val = {s.speed, s.filt, s.div};
    end

    // Next state: register port, sequencer, disable
    always_comb begin
        n = s;
        n.rdata = `TW_ZERO_BYTE;
        if (reg_rd) begin
            if (is_reg(reg_addr, `TW_CR_OFF)) begin
                n.rdata = cr_val;
            end else if (is_reg(reg_addr, `TW_SR_OFF)) begin
                n.rdata = sr_val;
            end else if (is_reg(reg_addr, `TW_CCR_OFF)) begin
                n.rdata = ccr_val;
            end else if (is_reg(reg_addr, `TW_DR_OFF)) begin
                n.rdata = s.data;
            end
        end
        // Status read arms the clear sequences; nack clears on read
        if (sr_rd) begin
            n.sr_seen = 1'b1;
            if (s.af) begin
                n.af = 1'b0;
                n.event_flag = 1'b0;
            end
        end
        if (reg_wr && is_reg(reg_addr, `TW_CCR_OFF)) begin
            n.speed = reg_wdata[`TW_CCR_SPD];
            n.filt = reg_wdata[`TW_CCR_FILT];
            n.div = reg_wdata[5:0];
        end
        if (dr_wr) begin
            n.data = reg_wdata;
        end
        // First enabling write only switches the block on
        if (cr_wr) begin
            if (!s.pe) begin
                n.pe = reg_wdata[`TW_CR_PE];
            end else begin
                n.pe = reg_wdata[`TW_CR_PE];
                n.start = reg_wdata[`TW_CR_START];
                n.ack = reg_wdata[`TW_CR_ACK];
                n.stop = reg_wdata[`TW_CR_STOP];
                n.irq_enable = reg_wdata[`TW_CR_ITE];
                if (reg_wdata[`TW_CR_START]) begin
                    n.mst = 1'b1;
                end
            end
        end
        unique case (s.st)
            TW_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (s.pe && s.start && scl_in && sda_in) begin
                    n = go_to(n, TW_GEN, 2'd1, 1'b0);
                end
            end
            TW_GEN: begin
                unique case (s.phase)
                    2'd0: begin
                        // SCL low, SDA set up for start or stop
                        n.scl_oe = 1'b1;
                        n.sda_oe = s.gstop;
                        n.cnt = s.cnt + 8'h01;
                        if (lo_done) begin
                            n.phase = 2'd1;
                            n.cnt = '0;
                        end
                    end
                    2'd1: begin
                        // SCL released; wait out any stretching
                        n.scl_oe = 1'b0;
                        if (scl_in) begin
                            n.cnt = s.cnt + 8'h01;
                            if (hi_done) begin
                                n.phase = 2'd2;
                                n.cnt = '0;
                                n.sda_oe = !s.gstop;
                            end
                        end
                    end
                    default: begin
                        n.cnt = s.cnt + 8'h01;
                        if (hi_done && s.gstop) begin
                            n.st = TW_IDLE;
                            n.stop = 1'b0;
                            n.mst = 1'b0;
                        end else if (hi_done) begin
                            n.scl_oe = 1'b1;
                            n.start = 1'b0;
                            n.sb = 1'b1;
                            n.event_flag = 1'b1;
                            n.st = TW_WADDR;
                        end
                    end
                endcase
            end
            TW_WADDR: begin
                // Start sent: hold SCL low for the address byte
                n.scl_oe = 1'b1;
                if (s.stop) begin
                    n = go_to(n, TW_GEN, 2'd0, 1'b1);
                end else if (dr_wr && s.sr_seen) begin
                    n = go_to(n, TW_BIT, 2'd0, 1'b0);
                    n.shreg = reg_wdata;
                    n.addr_ph = 1'b1;
                    n.rx_mode = reg_wdata[0];
                end
            end
            TW_BIT: begin
                if (s.phase == 2'd0) begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = drive;
                    n.cnt = s.cnt + 8'h01;
                    if (lo_done) begin
                        n.phase = 2'd1;
                        n.cnt = '0;
                    end
                end else if (scl_in && !hi_done) begin
                    n.scl_oe = 1'b0;
                    n.cnt = s.cnt + 8'h01;
                end else if (scl_in && s.bitn != `TW_LAST_BIT) begin
                    // Sample at end of high, then next bit
                    n.shreg = {s.shreg[6:0], sda_in};
                    n.bitn = s.bitn + 4'h1;
                    n.phase = 2'd0;
                    n.cnt = '0;
                end else if (scl_in) begin
                    // Ninth clock ends: decide the byte's event
                    n.addr_ph = 1'b0;
                    if (is_tx && sda_in) begin
                        n.af = 1'b1;
                        n.event_flag = 1'b1;
                        n.st = TW_FAIL;
                    end else if (is_tx && s.stop) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b1);
                    end else if (s.addr_ph) begin
                        n.event_flag = 1'b1;
                        n.scl_oe = 1'b1;
                        n.st = TW_HOLD;
                    end else begin
                        if (!is_tx) begin
                            n.data = s.shreg;
                        end
                        n.event_flag = 1'b1;
                        n.byte_done = 1'b1;
                        n.tx_direction = is_tx;
                        n.scl_oe = 1'b1;
                        n.st = TW_HOLD;
                    end
                end else begin
                    n.scl_oe = 1'b0;
                end
            end
            TW_HOLD: begin
                n.scl_oe = 1'b1;
                if (!s.byte_done) begin
                    // After address: wait status read, control write
                    if (cr_wr && s.sr_seen && n.stop) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b1);
                    end else if (cr_wr && s.sr_seen && n.start) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b0);
                    end else if (cr_wr && s.sr_seen && s.rx_mode) begin
                        n = go_to(n, TW_BIT, 2'd0, 1'b0);
                    end else if (cr_wr && s.sr_seen) begin
                        n.sr_seen = 1'b0;
                        n.event_flag = 1'b1;
                        n.byte_done = 1'b1;
                        n.tx_direction = 1'b1;
                    end
                end else if (s.tx_direction) begin
                    // Transmit: next byte launched by data write
                    if (dr_wr && s.sr_seen) begin
                        n = go_to(n, TW_BIT, 2'd0, 1'b0);
                        n.shreg = reg_wdata;
                    end else if (s.stop) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b1);
                    end else if (s.start) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b0);
                    end
                end else if (dr_rd && s.sr_seen) begin
                    // Receive: data read releases the bus
                    if (s.stop) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b1);
                    end else if (s.start) begin
                        n = go_to(n, TW_GEN, 2'd0, 1'b0);
                    end else begin
                        n = go_to(n, TW_BIT, 2'd0, 1'b0);
                    end
                end
            end
            TW_FAIL: begin
                // Nack: bus left free until start or stop
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (s.stop) begin
                    n = go_to(n, TW_GEN, 2'd0, 1'b1);
                end else if (s.start) begin
                    n = go_to(n, TW_GEN, 2'd0, 1'b0);
                end
            end
        endcase
        // Accesses that finish a sequence disarm it
        if (cr_wr || dr_wr || dr_rd) begin
            n.sr_seen = 1'b0;
        end
        // Disabled block holds control and status clear
        if (!n.pe) begin
            n.st = TW_IDLE;
            n.start = 1'b0;
            n.ack = 1'b0;
            n.stop = 1'b0;
            n.irq_enable = 1'b0;
            n.event_flag = 1'b0;
            n.af = 1'b0;
            n.tx_direction = 1'b0;
            n.byte_done = 1'b0;
            n.mst = 1'b0;
            n.sb = 1'b0;
            n.sr_seen = 1'b0;
            n.addr_ph = 1'b0;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end
        n.irq = n.irq_enable && n.event_flag;
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else if (clk_en) begin
            s <= n;
        end
    end

    // Outputs; pins are open drain and only ever pull low
    assign reg_rdata = s.rdata;
    assign irq = s.irq;
    assign pins_owned = s.pe;
    assign scl_oe = s.scl_oe;
    assign sda_oe = s.sda_oe;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_sr_rx;
        clk_en && sr_rd && s.byte_done && !s.tx_direction;
    endsequence
    sequence s_dr_rd;
        clk_en && dr_rd;
    endsequence

    chk_off_clear: assert property (!s.pe |-> !(s.event_flag || s.af || s.byte_done
        || s.sb || s.mst || s.irq_enable || s.ack || s.start || s.scl_oe
        || s.sda_oe))
        else $error("state not clear while disabled");
    chk_btf_stretch: assert property (s.byte_done |-> s.scl_oe)
        else $error("scl released while byte done");
    chk_af_release: assert property (s.af |-> !s.scl_oe)
        else $error("scl held during ack failure");
    chk_tra_btf: assert property (s.tx_direction |-> s.byte_done)
        else $error("direction set without byte done");
    chk_evf_cause: assert property ((s.byte_done || s.sb || s.af) |-> s.event_flag)
        else $error("event flag missing");
    chk_first_write: assert property ((clk_en && cr_wr && !s.pe)
        |=> !s.start && !s.irq_enable && !s.ack && !s.stop)
        else $error("first enable write set other bits");
    chk_sb_start: assert property ($rose(s.sb) |-> !s.start && s.mst)
        else $error("start request not cleared");
    chk_speed_keep: assert property ((clk_en && cr_wr
        && !reg_wdata[`TW_CR_PE]) |=> s.speed == $past(s.speed))
        else $error("speed changed on disable");
    chk_mst_set: assert property ((clk_en && cr_wr && s.pe
        && reg_wdata[`TW_CR_PE] && reg_wdata[`TW_CR_START]) |=> s.mst)
        else $error("master flag not set");
    chk_rx_release: assert property (s_sr_rx ##1 !(reg_wr || reg_rd)
        ##1 s_dr_rd
        |=> !s.byte_done && !s.event_flag)
        else $error("receive hold not released");
endmodule // tw_master

// file: tw_cfg.svh
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
// Register byte addresses
`define TW_CR_OFF 8'h1c
`define TW_SR_OFF 8'h1d
`define TW_CCR_OFF 8'h1e
`define TW_DR_OFF 8'h1f
// Control register fields
`define TW_CR_PE 5
`define TW_CR_START 3
`define TW_CR_ACK 2
`define TW_CR_STOP 1
`define TW_CR_ITE 0
// Status register fields
`define TW_SR_EVF 7
`define TW_SR_AF 6
`define TW_SR_TRA 5
`define TW_SR_BTF 3
`define TW_SR_MST 1
`define TW_SR_SB 0
// Clock setup fields
`define TW_CCR_SPD 7
`define TW_CCR_FILT 6
// Divider arithmetic and byte framing
`define TW_DIV_MIN 6'h03
`define TW_DIV_ADD 8'h03
`define TW_FM_EXTRA 8'h01
`define TW_LO_TRIM 8'h02
`define TW_LAST_BIT 4'h8
`define TW_ZERO_BYTE 8'h00
`endif

// file: tw_pkg.sv
package tw_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        TW_IDLE, TW_GEN, TW_WADDR, TW_BIT, TW_HOLD, TW_FAIL
    } tw_st_t;

    // Whole state of the master
    typedef struct packed {
        tw_st_t st;
        logic [1:0] phase;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic gstop;
        logic addr_ph;
        logic rx_mode;
        logic sr_seen;
        logic pe;
        logic start;
        logic ack;
        logic stop;
        logic irq_enable;
        logic event_flag;
        logic af;
        logic tx_direction;
        logic byte_done;
        logic mst;
        logic sb;
        logic speed;
        logic filt;
        logic [5:0] div;
        logic [7:0] data;
        logic [7:0] rdata;
        logic irq;
        logic scl_oe;
        logic sda_oe;
    } tw_state_t;
endpackage

// file: tw_slave_model.sv
`timescale 1ns/1ps
// Behavioural target device on the two-wire bus, never stretches SCL
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_byte,
    output logic sda_pull,
    output logic [7:0] got,
    output logic saw_nack
);
    logic act = 1'b0;
    logic aph = 1'b0;
    logic rd = 1'b0;
    logic ack_on = 1'b0;
    logic dat_on = 1'b0;
    logic [7:0] sh = 8'h00;
    int bitc = 0;
    int idx = 0;

    // Pull SDA low for an ack or a zero data bit, else the pull-up wins
    assign sda_pull = ack_on | (dat_on & ~tx_byte[3'(7 - idx)]);

    // Start opens a frame, stop closes it; a start also clears the nack mark
    always @(sda) begin
        if (scl === 1'b1) begin
            act = ~sda;
            aph = 1'b1;
            rd = 1'b0;
            bitc = 0;
            saw_nack = saw_nack & sda;
        end
    end

    // Shift in on the rising edge; a high ninth bit on a read ends it
    always @(posedge scl) begin
        if (act) begin
            if (bitc < 8)
                sh = {sh[6:0], sda};
            else if (rd && !aph && sda === 1'b1) begin
                act = 1'b0;
                saw_nack = 1'b1;
            end
            if (bitc == 8 && !aph && !rd)
                got = sh;
            if (bitc == 8)
                aph = 1'b0;
            bitc = (bitc == 8) ? 0 : bitc + 1;
        end
    end

    // Ack in the ninth low phase, data bits in the others on a read
    always @(negedge scl) begin
        ack_on = 1'b0;
        dat_on = 1'b0;
        if (act && bitc == 8) begin
            if (aph)
                rd = sh[0];
            if (aph && sh[7:1] != ADDR)
                act = 1'b0;
            ack_on = act & (aph | ~rd);
        end else if (act) begin
            dat_on = rd & ~aph;
            idx = bitc;
        end
    end
endmodule // tw_slave_model

// file: test_two_wire_single_master.sv
`timescale 1ns/1ps
`include "tw_cfg.svh"
module test_two_wire_single_master;
    localparam logic [6:0] SLV = 7'h2a;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, sl_got, v, last, ccr;
    logic irq, pins_owned, scl_oe, sda_oe, scl_out, sda_out;
    logic sl_pull, sl_nack, sda_dly;
    logic [7:0] sl_tx = 8'h00;
    logic [7:0] rnd = 8'h2f;
    logic [5:0] dv;
    int bad_count = 0;
    int n_tests = 0;
    int n;
    // Open-drain wires with pull-ups; the target sees SDA a little late
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | sl_pull);
    assign #1 sda_dly = sda;

    always #5 clk = ~clk;

    tw_master DUT (.clk(clk), .rstn(rstn), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .pins_owned(pins_owned), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    tw_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda_dly),
        .tx_byte(sl_tx), .sda_pull(sl_pull), .got(sl_got),
        .saw_nack(sl_nack));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Poll status until the masked bits match, bounded
    task automatic wait_sr(input logic [7:0] m, input logic [7:0] val);
        int k;
        k = 0;
        do begin
            rd(`TW_SR_OFF, v);
            k++;
        end while ((v & m) !== val && k < 3000);
        if ((v & m) !== val) begin
            bad_count++;
            end_of_test();
        end
    endtask

    task automatic wait_scl(input logic lv, inout int c);
        int k;
        k = 0;
        while (scl !== lv && k < 2000) begin
            @(posedge clk);
            #1;
            c++;
            k++;
        end
        if (scl !== lv) begin
            bad_count++;
            end_of_test();
        end
    endtask

    // Clock cycles from one SCL rise to the next
    task automatic meas(output int c);
        c = 0;
        wait_scl(1'b0, c);
        wait_scl(1'b1, c);
        c = 0;
        wait_scl(1'b0, c);
        wait_scl(1'b1, c);
    endtask

    task automatic hold_chk(input logic lv);
        repeat (20) @(posedge clk);
        chk({7'h0, scl}, {7'h0, lv});
    endtask

    // Start, then address byte; leaves the status of the next event in v
    task automatic open_link(input logic [6:0] a, input logic dir);
        wr(`TW_CR_OFF, 8'h2d);
        wait_sr(8'h81, 8'h81);
        chk(v, 8'h83);
        chk({7'h0, irq}, 8'h01);
        wr(`TW_DR_OFF, {a, dir});
        wait_sr(8'h80, 8'h80);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, read-only status, an unmapped address
        wr(8'h20, 8'hff);
        wr(`TW_SR_OFF, 8'hff);
        for (int a = 28; a <= 32; a++) begin
            rd(8'(a), v);
            chk(v, 8'h00);
        end
        wr(`TW_CR_OFF, 8'h27);
        rd(`TW_CR_OFF, v);
        chk(v, 8'h20);
        wr(`TW_CR_OFF, 8'h25);
        rd(`TW_CR_OFF, v);
        chk(v, 8'h25);
        chk({7'h0, pins_owned}, 8'h01);
        // Transmit three bytes in each speed class
        for (int sp = 0; sp < 2; sp++) begin
            rnd = lfsr(rnd);
            dv = 6'h03 + 6'(rnd[1:0]);
            ccr = {sp[0], 1'b0, dv};
            wr(`TW_CCR_OFF, ccr);
            open_link(SLV, 1'b0);
            chk(v, 8'h82);
            wr(`TW_CR_OFF, 8'h25);
            for (int b = 0; b < 3; b++) begin
                wait_sr(8'h88, 8'h88);
                chk(v, 8'haa);
                if (b > 0)
                    chk(sl_got, last);
                hold_chk(1'b0);
                rnd = lfsr(rnd);
                last = rnd;
                wr(`TW_DR_OFF, rnd);
                if (b == 2)
                    wr(`TW_CR_OFF, 8'h27);
                meas(n);
                chk(8'(n), 8'(sp ? 3 * (dv + 3) : 2 * (dv + 3) + 1));
            end
            wait_sr(8'hff, 8'h00);
            chk(v, 8'h00);
            chk(sl_got, last);
        end
        // Receive three bytes, nack on the last, stop before its read
        open_link(SLV, 1'b1);
        chk(v, 8'h82);
        rnd = lfsr(rnd);
        sl_tx = rnd;
        wr(`TW_CR_OFF, 8'h25);
        for (int b = 0; b < 3; b++) begin
            wait_sr(8'h88, 8'h88);
            chk(v, 8'h8a);
            hold_chk(1'b0);
            last = sl_tx;
            rnd = lfsr(rnd);
            sl_tx = rnd;
            if (b == 1)
                wr(`TW_CR_OFF, 8'h21);
            if (b == 2)
                wr(`TW_CR_OFF, 8'h23);
            if (b > 0)
                rd(`TW_SR_OFF, v);
            rd(`TW_DR_OFF, v);
            chk(v, last);
        end
        wait_sr(8'hff, 8'h00);
        chk(v, 8'h00);
        chk({7'h0, sl_nack}, 8'h01);
        // Address not acknowledged, then resume with a stop
        wr(`TW_CR_OFF, 8'h25);
        open_link(SLV ^ 7'h01, 1'b0);
        chk(v, 8'hc2);
        hold_chk(1'b1);
        wr(`TW_CR_OFF, 8'h27);
        wait_sr(8'hff, 8'h00);
        chk(v, 8'h00);
        // Disable in mid-frame while SCL is held
        wr(`TW_CR_OFF, 8'h2d);
        wait_sr(8'h81, 8'h81);
        wr(`TW_CR_OFF, 8'h00);
        rd(`TW_CR_OFF, v);
        chk(v, 8'h00);
        rd(`TW_SR_OFF, v);
        chk(v, 8'h00);
        rd(`TW_CCR_OFF, v);
        chk(v, ccr);
        chk({4'h0, pins_owned, scl_oe, sda_oe, irq}, 8'h00);
        chk({6'h00, scl_out, sda_out}, 8'h00);
        end_of_test();
    end
endmodule // test_two_wire_single_master
